// [hw/ira_regs.svh]
// register offsets, field positions, reset values of the register-access block
// assumes inclusion by ira_pkg and ira_top only
`ifndef IRA_REGS_SVH
`define IRA_REGS_SVH

`define IRA_OFS_PORT_SEL    8'h4C
`define IRA_OFS_CTRL        8'hB0
`define IRA_OFS_OFFSET      8'hB1
`define IRA_OFS_DATA        8'hB2
`define IRA_OFS_IDENT5      8'hF4
`define IRA_OFS_IDENT6      8'hF5
`define IRA_OFS_ALIAS0      8'hF8
`define IRA_OFS_ALIAS1      8'hF9
`define IRA_OFS_SPARE_FA    8'hFA
`define IRA_OFS_SPARE_FB    8'hFB

`define IRA_CTRL_SEL_HI     5
`define IRA_CTRL_SEL_LO     2
`define IRA_CTRL_AUTOINC    1

`define IRA_PAGE_PATTERN    4'h0
`define IRA_PAGE_CH0        4'h1
`define IRA_PAGE_CH1        4'h2
`define IRA_PAGE_ALL        4'h6

`define IRA_PG_LO           8'h01
`define IRA_PG_HI           8'h1F
`define IRA_PG_DEPTH        31
`define IRA_TM_LO           8'h40
`define IRA_TM_HI           8'h48
`define IRA_TM_DEPTH        9
`define IRA_TST_HI          8'h14
`define IRA_TST_DEPTH       21

`define IRA_OFS_PAT_CTL     8'h01
`define IRA_OFS_PAT_CFG     8'h02
`define IRA_PAT_ON_BIT      0
`define IRA_FIXED_BIT       7
`define IRA_BARS_HI         5
`define IRA_BARS_LO         4
`define IRA_BSIZE_HI        3
`define IRA_BSIZE_LO        0

`define IRA_RST_CTRL        5'h00
`define IRA_RST_OFFSET      8'h00
`define IRA_RST_PORT_SEL    8'h01
`define IRA_RST_ALIAS       7'h00
`define IRA_RST_PAT_CTL     8'h00
`define IRA_RST_PAT_CFG     8'h33

`endif

// [hw/ira_pkg.sv]
// types of the register-access block
// assumes ira_regs.svh on the include path
`include "ira_regs.svh"

package ira_pkg;

	typedef struct packed {
		logic [4:0]                             ctrl;
		logic [7:0]                             offset;
		logic [7:0]                             port_sel;
		logic [6:0]                             alias0;
		logic [6:0]                             alias1;
		logic [`IRA_PG_DEPTH-1:0][7:0]          pg;
		logic [`IRA_TM_DEPTH-1:0][7:0]          tm;
		logic [`IRA_TST_DEPTH-1:0][7:0]         ch0;
		logic [`IRA_TST_DEPTH-1:0][7:0]         ch1;
		logic [7:0]                             rdata;
		logic                                   rvalid;
		logic                                   acc_valid;
		logic [1:0]                             acc_port;
	} ira_state_t;

endpackage

// [hw/ira_top.sv]
// register access: alias decoding, indirect window, identification bytes
// assumes an i2c target front end delivering one decoded byte access per txn_valid
`timescale 1ns/1ps
`include "ira_regs.svh"

module ira_top #(
	parameter logic [7:0] IDENT5 = 8'hA5,            // arbitrary value
	parameter logic [7:0] IDENT6 = 8'h5A             // arbitrary value
) (
	input  wire logic       core_clk,                // 25 MHz clock
	input  wire logic       arst_n,                  // async reset, active low
	input  wire logic [6:0] main_dev_addr,           // device's own i2c address
	input  wire logic       txn_valid,               // one byte access this cycle
	input  wire logic       txn_write,               // 1 write, 0 read
	input  wire logic [6:0] txn_dev_addr,            // i2c address of the access
	input  wire logic [7:0] txn_offset,              // register offset
	input  wire logic [7:0] txn_wdata,               // write byte
	output logic      [7:0] rdata,                   // read byte
	output logic            rvalid,                  // read answer pulse
	output logic            acc_valid,               // accepted access pulse
	output logic      [1:0] acc_port,                // receive ports reached
	output logic            pattern_on,              // pattern generator enable
	output logic            fixed_colour_select,     // 1 fixed colours, 0 bars
	output logic      [1:0] colour_bar_count,        // bar count code
	output logic      [3:0] block_size               // fixed field size
);

	ira_pkg::ira_state_t s_reg;
	ira_pkg::ira_state_t s_next;

	logic       hit_main;
	logic       hit0;
	logic       hit1;
	logic       hit_any;
	logic       data_acc;
	logic [3:0] page_sel;

	function automatic logic in_test(input logic [7:0] off);
		in_test = (off <= `IRA_TST_HI);
	endfunction

	function automatic logic [7:0] page_read(input ira_pkg::ira_state_t st,
	                                         input logic [3:0] sel,
	                                         input logic [7:0] off);
		logic [7:0] i;
		i = 8'h00;
		page_read = 8'h00;
		case (sel)
			`IRA_PAGE_PATTERN:
			begin
				if (off >= `IRA_PG_LO && off <= `IRA_PG_HI)
				begin
					i = off - `IRA_PG_LO;
					page_read = st.pg[i];
				end
				else if (off >= `IRA_TM_LO && off <= `IRA_TM_HI)
				begin
					i = off - `IRA_TM_LO;
					page_read = st.tm[i];
				end
			end
			`IRA_PAGE_CH0, `IRA_PAGE_ALL:
			begin
				if (in_test(off))
					page_read = st.ch0[off];
			end
			`IRA_PAGE_CH1:
			begin
				if (in_test(off))
					page_read = st.ch1[off];
			end
			default:
				page_read = 8'h00;
		endcase
	endfunction

	assign page_sel = s_reg.ctrl[`IRA_CTRL_SEL_HI-1:`IRA_CTRL_SEL_LO-1];
	assign hit_main = (txn_dev_addr == main_dev_addr);
	assign hit0     = (s_reg.alias0 != 7'h00) && (txn_dev_addr == s_reg.alias0);
	assign hit1     = (s_reg.alias1 != 7'h00) && (txn_dev_addr == s_reg.alias1);
	assign hit_any  = txn_valid && (hit_main || hit0 || hit1);
	assign data_acc = hit_any && (txn_offset == `IRA_OFS_DATA);

	always_comb
	begin
		logic [7:0] idx;
		idx = 8'h00;
		s_next = s_reg;
		s_next.rvalid = 1'b0;
		s_next.acc_valid = 1'b0;
		if (hit_any)
		begin
			s_next.acc_valid = 1'b1;
			if (hit_main)
				s_next.acc_port = s_reg.port_sel[1:0];
			else if (hit0)
				s_next.acc_port = 2'b01;
			else
				s_next.acc_port = 2'b10;
			// shared registers below answer on every matched address
			if (txn_write)
			begin
				if (txn_offset == `IRA_OFS_PORT_SEL)
					s_next.port_sel = txn_wdata;
				else if (txn_offset == `IRA_OFS_CTRL)
					s_next.ctrl = txn_wdata[`IRA_CTRL_SEL_HI:`IRA_CTRL_AUTOINC];
				else if (txn_offset == `IRA_OFS_OFFSET)
					s_next.offset = txn_wdata;
				else if (txn_offset == `IRA_OFS_ALIAS0)
					s_next.alias0 = txn_wdata[7:1];
				else if (txn_offset == `IRA_OFS_ALIAS1)
					s_next.alias1 = txn_wdata[7:1];
				else if (txn_offset == `IRA_OFS_DATA)
				begin
					case (page_sel)
						`IRA_PAGE_PATTERN:
						begin
							if (s_reg.offset >= `IRA_PG_LO && s_reg.offset <= `IRA_PG_HI)
							begin
								idx = s_reg.offset - `IRA_PG_LO;
								s_next.pg[idx] = txn_wdata;
							end
							else if (s_reg.offset >= `IRA_TM_LO && s_reg.offset <= `IRA_TM_HI)
							begin
								idx = s_reg.offset - `IRA_TM_LO;
								s_next.tm[idx] = txn_wdata;
							end
						end
						`IRA_PAGE_CH0:
						begin
							if (in_test(s_reg.offset))
								s_next.ch0[s_reg.offset] = txn_wdata;
						end
						`IRA_PAGE_CH1:
						begin
							if (in_test(s_reg.offset))
								s_next.ch1[s_reg.offset] = txn_wdata;
						end
						`IRA_PAGE_ALL:
						begin
							if (in_test(s_reg.offset))
							begin
								s_next.ch0[s_reg.offset] = txn_wdata;
								s_next.ch1[s_reg.offset] = txn_wdata;
							end
						end
						default:
							idx = 8'h00;
					endcase
				end
			end
			else
			begin
				s_next.rvalid = 1'b1;
				if (txn_offset == `IRA_OFS_PORT_SEL)
					s_next.rdata = s_reg.port_sel;
				else if (txn_offset == `IRA_OFS_CTRL)
					s_next.rdata = {2'b00, s_reg.ctrl, 1'b0};
				else if (txn_offset == `IRA_OFS_OFFSET)
					s_next.rdata = s_reg.offset;
				else if (txn_offset == `IRA_OFS_DATA)
					s_next.rdata = page_read(s_reg, page_sel, s_reg.offset);
				else if (txn_offset == `IRA_OFS_IDENT5)
					s_next.rdata = IDENT5;
				else if (txn_offset == `IRA_OFS_IDENT6)
					s_next.rdata = IDENT6;
				else if (txn_offset == `IRA_OFS_ALIAS0)
					s_next.rdata = {s_reg.alias0, 1'b0};
				else if (txn_offset == `IRA_OFS_ALIAS1)
					s_next.rdata = {s_reg.alias1, 1'b0};
				else
					s_next.rdata = 8'h00;
			end
			if (data_acc && s_reg.ctrl[0])
				s_next.offset = s_reg.offset + 8'h01;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_reg <= '0;
			s_reg.ctrl <= `IRA_RST_CTRL;
			s_reg.offset <= `IRA_RST_OFFSET;
			s_reg.port_sel <= `IRA_RST_PORT_SEL;
			s_reg.alias0 <= `IRA_RST_ALIAS;
			s_reg.alias1 <= `IRA_RST_ALIAS;
			s_reg.pg[0] <= `IRA_RST_PAT_CTL;
			s_reg.pg[1] <= `IRA_RST_PAT_CFG;
		end
		else
			s_reg <= s_next;
	end

	assign rdata               = s_reg.rdata;
	assign rvalid              = s_reg.rvalid;
	assign acc_valid           = s_reg.acc_valid;
	assign acc_port            = s_reg.acc_port;
	assign pattern_on          = s_reg.pg[0][`IRA_PAT_ON_BIT];
	assign fixed_colour_select = s_reg.pg[1][`IRA_FIXED_BIT];
	assign colour_bar_count    = s_reg.pg[1][`IRA_BARS_HI:`IRA_BARS_LO];
	assign block_size          = s_reg.pg[1][`IRA_BSIZE_HI:`IRA_BSIZE_LO];

	a_ident_read: assert property (@(posedge core_clk) disable iff (!arst_n)
		hit_any && !txn_write && txn_offset == `IRA_OFS_IDENT5
		|=> rvalid && rdata == IDENT5)
		else $error("ident byte five read wrong");

	a_alias_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
		txn_valid && txn_dev_addr == 7'h00 && main_dev_addr != 7'h00 && s_reg.alias0 == 7'h00
		&& s_reg.alias1 == 7'h00 |=> !acc_valid && !rvalid)
		else $error("disabled alias decoder answered");

	a_alias0_port: assert property (@(posedge core_clk) disable iff (!arst_n)
		txn_valid && hit0 && !hit_main |=> acc_valid && acc_port == 2'b01)
		else $error("alias zero did not reach port 0");

	a_alias1_port: assert property (@(posedge core_clk) disable iff (!arst_n)
		txn_valid && hit1 && !hit0 && !hit_main |=> acc_port == 2'b10)
		else $error("alias one did not reach port 1");

	a_port_select: assert property (@(posedge core_clk) disable iff (!arst_n)
		txn_valid && hit_main |=> acc_port == $past(s_reg.port_sel[1:0]))
		else $error("main address ignored port select");

	a_auto_inc: assert property (@(posedge core_clk) disable iff (!arst_n)
		data_acc && s_reg.ctrl[0] |=> s_reg.offset == $past(s_reg.offset) + 8'h01)
		else $error("offset did not advance");

	a_offset_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
		data_acc && !s_reg.ctrl[0] |=> $stable(s_reg.offset))
		else $error("offset moved without auto-increment");

	a_pattern_on: assert property (@(posedge core_clk) disable iff (!arst_n)
		data_acc && txn_write && page_sel == `IRA_PAGE_PATTERN
		&& s_reg.offset == `IRA_OFS_PAT_CTL |=> pattern_on == $past(txn_wdata[0]))
		else $error("pattern enable not written");

	a_cfg_readback: assert property (@(posedge core_clk) disable iff (!arst_n)
		data_acc && !txn_write && page_sel == `IRA_PAGE_PATTERN
		&& s_reg.offset == `IRA_OFS_PAT_CFG
		|=> rvalid && rdata == {fixed_colour_select, $past(s_reg.pg[1][6]),
		colour_bar_count, block_size})
		else $error("config readback mismatch");

	a_spare_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
		hit_any && !txn_write && (txn_offset == `IRA_OFS_SPARE_FA
		|| txn_offset == `IRA_OFS_SPARE_FB) |=> rvalid && rdata == 8'h00)
		else $error("reserved byte not zero");

	a_ident_six: assert property (@(posedge core_clk) disable iff (!arst_n)
		hit_any && !txn_write && txn_offset == `IRA_OFS_IDENT6
		|=> rvalid && rdata == IDENT6)
		else $error("ident byte six read wrong");

	a_ro_ignore: assert property (@(posedge core_clk) disable iff (!arst_n)
		hit_any && txn_write && (txn_offset == `IRA_OFS_IDENT5 || txn_offset == `IRA_OFS_IDENT6
		|| txn_offset == `IRA_OFS_SPARE_FA || txn_offset == `IRA_OFS_SPARE_FB)
		|=> $stable({s_reg.ctrl, s_reg.offset, s_reg.port_sel, s_reg.alias0, s_reg.alias1}))
		else $error("read-only write changed state");

	a_page_all: assert property (@(posedge core_clk) disable iff (!arst_n)
		data_acc && txn_write && page_sel == `IRA_PAGE_ALL && in_test(s_reg.offset)
		|=> s_reg.ch0[$past(s_reg.offset)] == $past(txn_wdata)
		&& s_reg.ch1[$past(s_reg.offset)] == $past(txn_wdata))
		else $error("write-all page missed a channel");

	a_fixed_select: assert property (@(posedge core_clk) disable iff (!arst_n)
		data_acc && txn_write && page_sel == `IRA_PAGE_PATTERN && s_reg.offset == `IRA_OFS_PAT_CFG
		|=> fixed_colour_select == $past(txn_wdata[`IRA_FIXED_BIT]))
		else $error("fixed colour select not written");

	a_bar_count: assert property (@(posedge core_clk) disable iff (!arst_n)
		data_acc && txn_write && page_sel == `IRA_PAGE_PATTERN && s_reg.offset == `IRA_OFS_PAT_CFG
		|=> colour_bar_count == $past(txn_wdata[`IRA_BARS_HI:`IRA_BARS_LO]))
		else $error("colour bar count not written");

	a_block_size: assert property (@(posedge core_clk) disable iff (!arst_n)
		data_acc && txn_write && page_sel == `IRA_PAGE_PATTERN && s_reg.offset == `IRA_OFS_PAT_CFG
		|=> block_size == $past(txn_wdata[`IRA_BSIZE_HI:`IRA_BSIZE_LO]))
		else $error("block size not written");

	a_ctrl_page: assert property (@(posedge core_clk) disable iff (!arst_n)
		hit_any && txn_write && txn_offset == `IRA_OFS_CTRL |=> page_sel == $past(txn_wdata[5:2]))
		else $error("page select not taken from control");

endmodule

// [test/ira_host.sv]
// partner model: i2c host front end issuing decoded byte accesses
// assumes calls only at falling clock edges
`timescale 1ns/1ps

module ira_host (
	input  wire logic       core_clk,     // bench clock
	output logic            txn_valid,    // access strobe
	output logic            txn_write,    // 1 write, 0 read
	output logic      [6:0] txn_dev_addr, // target address
	output logic      [7:0] txn_offset,   // register offset
	output logic      [7:0] txn_wdata     // write byte
);
	initial
	begin
		txn_valid = 1'b0;
		txn_write = 1'b0;
		txn_dev_addr = 7'h00;
		txn_offset = 8'h00;
		txn_wdata = 8'h00;
	end

	// one access held for one cycle; consecutive calls run back to back
	task automatic access(input logic w, input logic [6:0] d, input logic [7:0] o,
		input logic [7:0] v);
		txn_valid = 1'b1;
		txn_write = w;
		txn_dev_addr = d;
		txn_offset = o;
		txn_wdata = v;
		@(negedge core_clk);
	endtask

	// strobe drops low; the other lines show the inverse of their last value
	task automatic idle();
		txn_valid = 1'b0;
		txn_write = ~txn_write;
		txn_dev_addr = ~txn_dev_addr;
		txn_offset = ~txn_offset;
		txn_wdata = ~txn_wdata;
		@(negedge core_clk);
	endtask
endmodule

// [test/testbench.sv]
// self-checking bench: random byte accesses against an integer model
// assumes ira_top and ira_host compiled before it
`timescale 1ns/1ps

module testbench;
	localparam logic [6:0] MAIN = 7'h3D;
	localparam logic [7:0] ID5  = 8'hC3; // arbitrary value
	localparam logic [7:0] ID6  = 8'h3C; // arbitrary value
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        txn_valid, txn_write, rvalid, acc_valid, pattern_on, fixed_colour_select;
	logic [6:0]  txn_dev_addr;
	logic [7:0]  txn_offset, txn_wdata, rdata;
	logic [1:0]  acc_port, colour_bar_count;
	logic [3:0]  block_size;
	logic [31:0] seed = 32'hD0CBF1BD;
	int          mismatches = 0;
	int          num_checks = 0;
	int          pg[256];
	int          ch0[21];
	int          ch1[21];
	int          ctrl, ofs, psel, al0, al1, eport;
	logic [7:0]  offs[16] = '{8'h4C, 8'hB0, 8'hB1, 8'hB2, 8'hB2, 8'hB2, 8'hB2, 8'hF4,
		8'hF5, 8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hB2, 8'h02, 8'h01};

	always #20 core_clk = ~core_clk;

	ira_top #(.IDENT5(ID5), .IDENT6(ID6)) u_dut (.core_clk(core_clk), .arst_n(arst_n),
		.main_dev_addr(MAIN), .txn_valid(txn_valid), .txn_write(txn_write),
		.txn_dev_addr(txn_dev_addr), .txn_offset(txn_offset), .txn_wdata(txn_wdata),
		.rdata(rdata), .rvalid(rvalid), .acc_valid(acc_valid), .acc_port(acc_port),
		.pattern_on(pattern_on), .fixed_colour_select(fixed_colour_select),
		.colour_bar_count(colour_bar_count), .block_size(block_size));
	ira_host u_host (.core_clk(core_clk), .txn_valid(txn_valid), .txn_write(txn_write),
		.txn_dev_addr(txn_dev_addr), .txn_offset(txn_offset), .txn_wdata(txn_wdata));

	function automatic logic [31:0] nxt();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic int model(logic w, int dev, int off, int wd);
		int r = 0;
		int s = (ctrl >> 2) & 15;
		int p0 = (ofs >= 1 && ofs <= 31) || (ofs >= 64 && ofs <= 72);
		if (dev == MAIN) eport = psel & 3;
		else if (al0 != 0 && dev == al0) eport = 1;
		else if (al1 != 0 && dev == al1) eport = 2;
		else return -1;
		case (off)
		8'h4C: if (w) psel = wd; else r = psel;
		8'hB0: if (w) ctrl = wd & 8'h3E; else r = ctrl;
		8'hB1: if (w) ofs = wd; else r = ofs;
		8'hB2:
		begin
			if (w && s == 0 && p0) pg[ofs] = wd;
			if (w && (s == 1 || s == 6) && ofs <= 20) ch0[ofs] = wd;
			if (w && (s == 2 || s == 6) && ofs <= 20) ch1[ofs] = wd;
			if (!w && s == 0 && p0) r = pg[ofs];
			if (!w && (s == 1 || s == 6) && ofs <= 20) r = ch0[ofs];
			if (!w && s == 2 && ofs <= 20) r = ch1[ofs];
			if (ctrl & 2) ofs = (ofs + 1) & 255;
		end
		8'hF4: r = ID5;
		8'hF5: r = ID6;
		8'hF8: if (w) al0 = wd >> 1; else r = al0 << 1;
		8'hF9: if (w) al1 = wd >> 1; else r = al1 << 1;
		default: r = 0;
		endcase
		return r;
	endfunction

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask

	task automatic chk_pat();
		chk_byte({pattern_on, fixed_colour_select, colour_bar_count, block_size},
			8'(((pg[1] & 1) << 7) | ((pg[2] >> 1) & 8'h40) | (pg[2] & 8'h3F)));
	endtask

	task automatic run(input logic w, input logic [6:0] d, input logic [7:0] o,
		input logic [7:0] v);
		int r;
		r = model(w, d, o, v);
		u_host.access(w, d, o, v);
		chk_bit(acc_valid, r >= 0);
		chk_bit(rvalid, r >= 0 && !w);
		chk_byte({6'h00, acc_port}, 8'(eport));
		if (r >= 0 && !w) chk_byte(rdata, 8'(r));
		chk_pat();
	endtask

	task automatic do_reset();
		arst_n = 1'b0;
		repeat (6) @(negedge core_clk);
		foreach (pg[i]) pg[i] = 0;
		foreach (ch0[i]) ch0[i] = 0;
		foreach (ch1[i]) ch1[i] = 0;
		pg[2] = 8'h33;
		{ctrl, ofs, psel, al0, al1, eport} = {32'd0, 32'd0, 32'd1, 32'd0, 32'd0, 32'd0};
		arst_n = 1'b1;
		chk_pat();
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		#120000;
		mismatches++;
		end_of_test();
	end

	initial
	begin
		logic [31:0] x;
		logic [7:0]  o;
		logic [7:0]  v;
		@(negedge core_clk);
		for (int k = 0; k < 2; k++)
		begin
			do_reset();
			run(1'b1, MAIN, 8'hF8, 8'h42);
			run(1'b1, 7'h21, 8'hF9, 8'h44);
			run(1'b1, 7'h22, 8'hB0, 8'h02);
			run(1'b1, MAIN, 8'hB1, 8'h01);
			run(1'b1, MAIN, 8'hB2, 8'h01);
			run(1'b1, MAIN, 8'hB2, 8'hA5);
			run(1'b1, MAIN, 8'hB0, 8'h1A);
			run(1'b1, MAIN, 8'hB1, 8'h14);
			run(1'b1, MAIN, 8'hB2, 8'h5C);
			run(1'b1, MAIN, 8'hF4, 8'h00);
			run(1'b1, MAIN, 8'hB0, 8'h08);
			run(1'b1, MAIN, 8'hB1, 8'h14);
			run(1'b0, MAIN, 8'hB2, 8'h00);
			run(1'b1, MAIN, 8'hB0, 8'h02);
			run(1'b1, MAIN, 8'hB1, 8'h02);
			run(1'b0, MAIN, 8'hB2, 8'h00);
			run(1'b1, MAIN, 8'hB0, 8'h3C);
			run(1'b1, MAIN, 8'hB2, 8'hFF);
			run(1'b0, MAIN, 8'hB2, 8'h00);
			for (int i = 0; i < 400; i++)
			begin
				x = nxt();
				o = offs[x[19:16]];
				v = x[31:24];
				if (o == 8'hB0) v = v & 8'h1E;
				if (o == 8'hB1) v = v & 8'h5F;
				if (o == 8'h4C) v = v & 8'h03;
				case (x[1:0])
				2'd0: run(x[2], MAIN, o, v);
				2'd1: run(x[2], 7'(al0), o, v);
				2'd2: run(x[2], 7'(al1), o, v);
				default: run(x[2], x[14:8], o, v);
				endcase
				if (x[7:5] == 3'd0) u_host.idle();
			end
			u_host.idle();
		end
		end_of_test();
	end
endmodule
